// file: rtl/port_bus_pkg.sv
package port_bus_pkg;
  localparam logic [7:0] ADDR_PORT0  = 8'h80;
  localparam logic [7:0] ADDR_PTR_LO = 8'h82;
  localparam logic [7:0] ADDR_PTR_HI = 8'h83;
  localparam logic [7:0] ADDR_AUX    = 8'h8E;
  localparam logic [7:0] ADDR_PORT1  = 8'h90;
  localparam logic [7:0] ADDR_PORT2  = 8'hA0;
  localparam logic [7:0] ADDR_PORT3  = 8'hB0;
  localparam logic [7:0] PORT_RESET  = 8'hFF;
  localparam logic [7:0] PTR_RESET   = 8'h00;
  localparam logic [7:0] READ_NONE   = 8'h00;
  localparam logic       ALE_OFF_RESET = 1'b0;
  localparam int ALE_OFF_BIT = 0;
  localparam int MCYC_CLKS     = 12;
  localparam int RST_HOLD_MCYC = 2;
  localparam logic [3:0] PH_FIRST     = 4'h0;
  localparam logic [3:0] PH_LAST      = 4'hB;
  localparam logic [3:0] PH_STEP      = 4'h1;
  localparam logic [3:0] PH_SLOT_B    = 4'h6;
  localparam logic [3:0] PH_STB_BEG   = 4'h3;
  localparam logic [3:0] PH_STB_END   = 4'hA;
  localparam logic [3:0] PH_RD_SAMPLE = 4'hA;
  localparam logic [3:0] SUB_ALE_END  = 4'h1;
  localparam logic [3:0] SUB_ADDR_END = 4'h2;
  localparam logic [3:0] SUB_STB_BEG  = 4'h3;
  localparam logic [3:0] SUB_SAMPLE   = 4'h4;
  localparam int RXD_BIT  = 0;
  localparam int TXD_BIT  = 1;
  localparam int IRQ0_BIT = 2;
  localparam int IRQ1_BIT = 3;
  localparam int TMR0_BIT      = 4;
  localparam int TMR1_BIT      = 5;
  localparam int WR_BIT        = 6;
  localparam int RD_BIT        = 7;
  localparam int TMR2_BIT      = 0;
  localparam int TMR2_TRIG_BIT = 1;
  typedef struct packed {
    logic [7:0] addr;
    logic       wrEn;
    logic       rdEn;
    logic [7:0] wrData;
  } sfr_req_t;
  typedef struct packed {
    logic       write;
    logic       usePtr;
    logic [7:0] indAddr;
    logic [7:0] wrData;
  } xdata_req_t;
endpackage

// file: rtl/quasi_port.sv
`timescale 1ns/10ps
`default_nettype none
module quasi_port #(
  parameter int WIDTH      = 8,
  parameter bit OPEN_DRAIN = 1'b0
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] latch,
  input  wire logic [WIDTH-1:0] altVal,
  input  wire logic             busDrive,
  input  wire logic             busFloat,
  input  wire logic [WIDTH-1:0] busVal,
  output logic      [WIDTH-1:0] pinOut,
  output logic      [WIDTH-1:0] pinOe
);
  if (WIDTH < 1) begin : g_chk
    $error("quasi_port needs at least one bit");
  end

  // unless the bus drives or floats the pin, a one in latch and altVal never drives; only a zero in either pulls the pin down
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    wire logic val = latch[i] & altVal[i];
    wire logic outD = busDrive ? busVal[i] : (OPEN_DRAIN ? 1'b0 : val);
    wire logic oeD = busDrive | (~busFloat & ~val);
    always_ff @(posedge core_clk) begin
      if (!rstn) begin
        pinOut[i] <= 1'b0;
        pinOe[i]  <= 1'b0;
      end else begin
        pinOut[i] <= outD;
        pinOe[i]  <= oeD;
      end
    end
  end

  property p_quasi;
    @(posedge core_clk) disable iff (!rstn)
    (!busDrive && !busFloat) |=> (pinOe == ~$past(latch & altVal));
  endproperty
  a_quasi: assert property (p_quasi) else $error("port drives a latched one");
endmodule
`default_nettype wire

// file: rtl/rst_filter.sv
`timescale 1ns/10ps
`default_nettype none
module rst_filter #(
  parameter int HOLD_CLKS = port_bus_pkg::RST_HOLD_MCYC * port_bus_pkg::MCYC_CLKS
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic rstPin,
  input  wire logic extFetchSelectN,
  input  wire logic lockBit1,
  output logic      pinReset_q,
  output logic      extExec_q
);
  localparam int CW = $clog2(HOLD_CLKS + 1);
  localparam logic [CW-1:0] HOLD = CW'(HOLD_CLKS);
  localparam logic [CW-1:0] ONE  = CW'(1);
  if (HOLD_CLKS < 1) begin : g_chk
    $error("reset hold must be at least one cycle");
  end

  logic [CW-1:0] cnt_q;
  logic          arm_q;
  logic          strapLat_q;
  wire  logic [CW-1:0] cntD = !rstPin ? '0 : ((cnt_q == HOLD) ? cnt_q : cnt_q + ONE);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_q      <= '0;
      pinReset_q <= 1'b0;
    end else begin
      cnt_q      <= cntD;
      pinReset_q <= rstPin && (cntD == HOLD);
    end
  end

  // strap caught in the cycle after any reset releases and throughout a pin reset, never under core reset
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      arm_q     <= 1'b1;
      strapLat_q <= 1'b0;
      extExec_q <= 1'b0;
    end else begin
      arm_q <= pinReset_q;
      if (arm_q) begin
        strapLat_q <= extFetchSelectN;
      end
      extExec_q <= lockBit1 ? ~strapLat_q : ~extFetchSelectN;
    end
  end

  property p_rst_min;
    @(posedge core_clk) disable iff (!rstn)
    $rose(pinReset_q) |-> ($past(rstPin) && ($past(cnt_q) == HOLD - ONE));
  endproperty
  a_rst_min: assert property (p_rst_min) else $error("reset taken before hold time");

  property p_rst_drop;
    @(posedge core_clk) disable iff (!rstn)
    (rstPin && (cnt_q == HOLD)) |=> pinReset_q || !$past(rstPin);
  endproperty
  a_rst_drop: assert property (p_rst_drop) else $error("held reset not recognized");

  property p_strap_hold;
    @(posedge core_clk) disable iff (!rstn)
    ($past(lockBit1) && $past(lockBit1, 2) && !$past(arm_q, 2)) |-> $stable(extExec_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("locked fetch select changed");
endmodule
`default_nettype wire

// file: rtl/port_bus_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module port_bus_ctrl (
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  input  wire port_bus_pkg::sfr_req_t   sfrReq,
  output logic [7:0]                    sfrRdData_q,
  input  wire logic [15:0]              fetchAddr,
  output logic [7:0]                    fetchData_q,
  output logic                          fetchValid_q,
  input  wire logic                     codeConstActive,
  input  wire logic                     xReq,
  input  wire port_bus_pkg::xdata_req_t xReqData,
  output logic [7:0]                    xRdData_q,
  output logic                          xDone_q,
  output logic                          aleOut_q,
  output logic                          programFetchStrobeN_q,
  input  wire logic                     extFetchSelectN,
  input  wire logic                     lockBit1,
  input  wire logic                     rstPin,
  output logic                          extExec,
  output logic                          deviceReset,
  input  wire logic [7:0]               p0In,
  output logic [7:0]                    p0Out,
  output logic [7:0]                    p0Oe,
  input  wire logic [7:0]               p1In,
  output logic [7:0]                    p1Out,
  output logic [7:0]                    p1Oe,
  input  wire logic [7:0]               p2In,
  output logic [7:0]                    p2Out,
  output logic [7:0]                    p2Oe,
  input  wire logic [7:0]               p3In,
  output logic [7:0]                    p3Out,
  output logic [7:0]                    p3Oe,
  input  wire logic                     txdOut,
  input  wire logic                     timer2ClkOut,
  input  wire logic                     timer2ClkOutEn,
  output logic                          serialRxd_q,
  output logic                          extIrq0Pin_q,
  output logic                          extIrq1Pin_q,
  output logic                          timer0CountPin_q,
  output logic                          timer1CountPin_q,
  output logic                          timer2CountInput_q,
  output logic                          timer2TriggerInput_q
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    return a == ref_a;
  endfunction

  logic                     blkRstN;
  logic [7:0]               p0Lat_q;
  logic [7:0]               p1Lat_q;
  logic [7:0]               p2Lat_q;
  logic [7:0]               p3Lat_q;
  logic [7:0]               ptrLo_q;
  logic [7:0]               ptrHi_q;
  logic                     aleOff_q;
  logic [3:0]               phase_q;
  logic                     dataCyc_q;
  port_bus_pkg::xdata_req_t req_q;
  logic [15:0]              fAddr_q;
  logic [7:0]               alt1;
  logic [7:0]               alt3;

  // a recognized pin reset acts like the core reset on all state here except the reset filter
  assign blkRstN = rstn & ~deviceReset;

  rst_filter u_rst (
    .core_clk        (core_clk),
    .rstn            (rstn),
    .rstPin          (rstPin),
    .extFetchSelectN (extFetchSelectN),
    .lockBit1        (lockBit1),
    .pinReset_q      (deviceReset),
    .extExec_q       (extExec)
  );

  wire logic wrP0  = sfrReq.wrEn & hit(sfrReq.addr, port_bus_pkg::ADDR_PORT0);
  wire logic wrP1  = sfrReq.wrEn & hit(sfrReq.addr, port_bus_pkg::ADDR_PORT1);
  wire logic wrP2  = sfrReq.wrEn & hit(sfrReq.addr, port_bus_pkg::ADDR_PORT2);
  wire logic wrP3  = sfrReq.wrEn & hit(sfrReq.addr, port_bus_pkg::ADDR_PORT3);
  wire logic wrLo  = sfrReq.wrEn & hit(sfrReq.addr, port_bus_pkg::ADDR_PTR_LO);
  wire logic wrHi  = sfrReq.wrEn & hit(sfrReq.addr, port_bus_pkg::ADDR_PTR_HI);
  wire logic wrAux = sfrReq.wrEn & hit(sfrReq.addr, port_bus_pkg::ADDR_AUX);

  // port reads return the pins, so inputs work once a one is latched
  wire logic [7:0] rdMux =
    hit(sfrReq.addr, port_bus_pkg::ADDR_PORT0)  ? p0In :
    hit(sfrReq.addr, port_bus_pkg::ADDR_PORT1)  ? p1In :
    hit(sfrReq.addr, port_bus_pkg::ADDR_PORT2)  ? p2In :
    hit(sfrReq.addr, port_bus_pkg::ADDR_PORT3)  ? p3In :
    hit(sfrReq.addr, port_bus_pkg::ADDR_PTR_LO) ? ptrLo_q :
    hit(sfrReq.addr, port_bus_pkg::ADDR_PTR_HI) ? ptrHi_q :
    hit(sfrReq.addr, port_bus_pkg::ADDR_AUX)    ? {7'h00, aleOff_q} :
    port_bus_pkg::READ_NONE;

  // only software writes touch the latches; bus cycles leave them alone
  always_ff @(posedge core_clk) begin
    if (!blkRstN) begin
      p0Lat_q  <= port_bus_pkg::PORT_RESET;
      p1Lat_q  <= port_bus_pkg::PORT_RESET;
      p2Lat_q  <= port_bus_pkg::PORT_RESET;
      p3Lat_q  <= port_bus_pkg::PORT_RESET;
      ptrLo_q  <= port_bus_pkg::PTR_RESET;
      ptrHi_q  <= port_bus_pkg::PTR_RESET;
      aleOff_q <= port_bus_pkg::ALE_OFF_RESET;
    end else begin
      if (wrP0) p0Lat_q <= sfrReq.wrData;
      if (wrP1) p1Lat_q <= sfrReq.wrData;
      if (wrP2) p2Lat_q <= sfrReq.wrData;
      if (wrP3) p3Lat_q <= sfrReq.wrData;
      if (wrLo) ptrLo_q <= sfrReq.wrData;
      if (wrHi) ptrHi_q <= sfrReq.wrData;
      if (wrAux) aleOff_q <= sfrReq.wrData[port_bus_pkg::ALE_OFF_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!blkRstN) begin
      sfrRdData_q <= port_bus_pkg::READ_NONE;
    end else if (sfrReq.rdEn) begin
      sfrRdData_q <= rdMux;
    end
  end

  // machine cycle of twelve clocks in two slots of six
  wire logic       phaseLast = phase_q == port_bus_pkg::PH_LAST;
  wire logic [3:0] phaseD    = phaseLast ? port_bus_pkg::PH_FIRST : phase_q + port_bus_pkg::PH_STEP;
  wire logic       slotB     = phase_q >= port_bus_pkg::PH_SLOT_B;
  wire logic [3:0] sub       = slotB ? phase_q - port_bus_pkg::PH_SLOT_B : phase_q;
  wire logic       takeReq   = phaseLast & xReq & ~dataCyc_q;

  always_ff @(posedge core_clk) begin
    if (!blkRstN) begin
      phase_q   <= port_bus_pkg::PH_FIRST;
      dataCyc_q <= 1'b0;
      req_q     <= '0;
    end else begin
      phase_q <= phaseD;
      if (phaseLast) dataCyc_q <= takeReq;
      if (takeReq) req_q <= xReqData;
    end
  end

  wire logic aleWin     = sub <= port_bus_pkg::SUB_ALE_END;
  wire logic addrWin    = sub <= port_bus_pkg::SUB_ADDR_END;
  wire logic strobeWin  = sub >= port_bus_pkg::SUB_STB_BEG;
  wire logic firstSub   = sub == port_bus_pkg::PH_FIRST;
  wire logic fetchSlot  = extExec & ~dataCyc_q;
  wire logic alePulse   = aleWin & ~(dataCyc_q & slotB);
  // external execution overrides the disable bit
  wire logic aleAllowed = extExec | ~aleOff_q | dataCyc_q | codeConstActive;
  wire logic aleD       = aleAllowed ? alePulse : 1'b1;
  wire logic fetchStbD  = ~(fetchSlot & strobeWin);
  wire logic fetchTake  = fetchSlot & (sub == port_bus_pkg::SUB_SAMPLE);

  always_ff @(posedge core_clk) begin
    if (!blkRstN) begin
      aleOut_q              <= 1'b0;
      programFetchStrobeN_q <= 1'b1;
      fAddr_q               <= '0;
    end else begin
      aleOut_q              <= aleD;
      programFetchStrobeN_q <= fetchStbD;
      if (firstSub) fAddr_q <= fetchAddr;
    end
  end

  // fetch data taken while the strobe is low on the pins
  always_ff @(posedge core_clk) begin
    if (!blkRstN) begin
      fetchData_q  <= '0;
      fetchValid_q <= 1'b0;
    end else begin
      fetchValid_q <= fetchTake;
      if (fetchTake) fetchData_q <= p0In;
    end
  end

  wire logic [15:0] fetchA      = firstSub ? fetchAddr : fAddr_q;
  wire logic        dataAddrWin = dataCyc_q & ~slotB & addrWin;
  wire logic        dataStb     = dataCyc_q & (phase_q >= port_bus_pkg::PH_STB_BEG)
                                  & (phase_q <= port_bus_pkg::PH_STB_END);
  wire logic        wrStbN      = ~(dataStb & req_q.write);
  wire logic        rdStbN      = ~(dataStb & ~req_q.write);
  wire logic        rdTake      = dataCyc_q & (phase_q == port_bus_pkg::PH_RD_SAMPLE);
  wire logic [7:0]  dataLo      = req_q.usePtr ? ptrLo_q : req_q.indAddr;
  wire logic        p0Drive     = (fetchSlot & addrWin) | dataAddrWin
                                  | (dataCyc_q & ~dataAddrWin & req_q.write);
  wire logic        p0Float     = (fetchSlot & ~addrWin)
                                  | (dataCyc_q & ~dataAddrWin & ~req_q.write);
  wire logic [7:0]  p0Bus       = dataAddrWin ? dataLo : (dataCyc_q ? req_q.wrData : fetchA[7:0]);
  wire logic        p2Drive     = fetchSlot | (dataCyc_q & req_q.usePtr);
  wire logic [7:0]  p2Bus       = dataCyc_q ? ptrHi_q : fetchA[15:8];

  always_ff @(posedge core_clk) begin
    if (!blkRstN) begin
      xRdData_q <= '0;
      xDone_q   <= 1'b0;
    end else begin
      xDone_q <= rdTake;
      if (rdTake && !req_q.write) xRdData_q <= p0In;
    end
  end

  always_comb begin
    alt1 = '1;
    alt1[port_bus_pkg::TMR2_BIT] = timer2ClkOutEn ? timer2ClkOut : 1'b1;
    alt3 = '1;
    alt3[port_bus_pkg::TXD_BIT] = txdOut;
    alt3[port_bus_pkg::WR_BIT]  = wrStbN;
    alt3[port_bus_pkg::RD_BIT]  = rdStbN;
  end

  quasi_port #(.WIDTH(8), .OPEN_DRAIN(1'b1)) u_p0 (
    .core_clk (core_clk),
    .rstn     (blkRstN),
    .latch    (p0Lat_q),
    .altVal   ('1),
    .busDrive (p0Drive),
    .busFloat (p0Float),
    .busVal   (p0Bus),
    .pinOut   (p0Out),
    .pinOe    (p0Oe)
  );

  quasi_port #(.WIDTH(8), .OPEN_DRAIN(1'b0)) u_p1 (
    .core_clk (core_clk),
    .rstn     (blkRstN),
    .latch    (p1Lat_q),
    .altVal   (alt1),
    .busDrive (1'b0),
    .busFloat (1'b0),
    .busVal   ('0),
    .pinOut   (p1Out),
    .pinOe    (p1Oe)
  );

  quasi_port #(.WIDTH(8), .OPEN_DRAIN(1'b0)) u_p2 (
    .core_clk (core_clk),
    .rstn     (blkRstN),
    .latch    (p2Lat_q),
    .altVal   ('1),
    .busDrive (p2Drive),
    .busFloat (1'b0),
    .busVal   (p2Bus),
    .pinOut   (p2Out),
    .pinOe    (p2Oe)
  );

  quasi_port #(.WIDTH(8), .OPEN_DRAIN(1'b0)) u_p3 (
    .core_clk (core_clk),
    .rstn     (blkRstN),
    .latch    (p3Lat_q),
    .altVal   (alt3),
    .busDrive (1'b0),
    .busFloat (1'b0),
    .busVal   ('0),
    .pinOut   (p3Out),
    .pinOe    (p3Oe)
  );

  // alternate pin inputs handed to the timers, serial port and interrupts
  always_ff @(posedge core_clk) begin
    if (!blkRstN) begin
      serialRxd_q          <= 1'b1;
      extIrq0Pin_q         <= 1'b1;
      extIrq1Pin_q         <= 1'b1;
      timer0CountPin_q     <= 1'b1;
      timer1CountPin_q     <= 1'b1;
      timer2CountInput_q   <= 1'b1;
      timer2TriggerInput_q <= 1'b1;
    end else begin
      serialRxd_q          <= p3In[port_bus_pkg::RXD_BIT];
      extIrq0Pin_q         <= p3In[port_bus_pkg::IRQ0_BIT];
      extIrq1Pin_q         <= p3In[port_bus_pkg::IRQ1_BIT];
      timer0CountPin_q     <= p3In[port_bus_pkg::TMR0_BIT];
      timer1CountPin_q     <= p3In[port_bus_pkg::TMR1_BIT];
      timer2CountInput_q   <= p1In[port_bus_pkg::TMR2_BIT];
      timer2TriggerInput_q <= p1In[port_bus_pkg::TMR2_TRIG_BIT];
    end
  end

  sequence s_ale_pair;
    aleOut_q ##1 aleOut_q ##1 !aleOut_q [*4] ##1 aleOut_q;
  endsequence

  sequence s_fetch_pair;
    !programFetchStrobeN_q [*3] ##1 programFetchStrobeN_q [*3] ##1 !programFetchStrobeN_q;
  endsequence

  property p_ale_rate;
    @(posedge core_clk) disable iff (!blkRstN)
    ($rose(aleOut_q) && extExec && !dataCyc_q && !slotB) |-> s_ale_pair;
  endproperty
  a_ale_rate: assert property (p_ale_rate) else $error("latch pulse off its rate");

  property p_ale_skip;
    @(posedge core_clk) disable iff (!blkRstN)
    (dataCyc_q && phase_q == port_bus_pkg::PH_SLOT_B) |-> ##1 !aleOut_q [*6];
  endproperty
  a_ale_skip: assert property (p_ale_skip) else $error("latch pulse not skipped");

  property p_ale_off;
    @(posedge core_clk) disable iff (!blkRstN)
    (aleOff_q && !extExec && !dataCyc_q && !codeConstActive) |=> aleOut_q;
  endproperty
  a_ale_off: assert property (p_ale_off) else $error("latch pulse while disabled");

  property p_fetch_twice;
    @(posedge core_clk) disable iff (!blkRstN)
    ($fell(programFetchStrobeN_q) && !slotB && !dataCyc_q) |-> s_fetch_pair;
  endproperty
  a_fetch_twice: assert property (p_fetch_twice) else $error("fetch strobe not twice");

  property p_fetch_skip;
    @(posedge core_clk) disable iff (!blkRstN)
    $rose(dataCyc_q) |-> ##1 programFetchStrobeN_q [*8];
  endproperty
  a_fetch_skip: assert property (p_fetch_skip) else $error("fetch strobe in data access");

  property p_p2_high;
    @(posedge core_clk) disable iff (!blkRstN)
    (dataCyc_q && req_q.usePtr) |=> (p2Oe == '1) && (p2Out == $past(ptrHi_q));
  endproperty
  a_p2_high: assert property (p_p2_high) else $error("port 2 not high address");

  property p_p2_latch;
    @(posedge core_clk) disable iff (!blkRstN)
    (dataCyc_q && !req_q.usePtr) |=> (p2Out == $past(p2Lat_q)) && (p2Oe == ~$past(p2Lat_q));
  endproperty
  a_p2_latch: assert property (p_p2_latch) else $error("port 2 not own latch");

  property p_p0_open;
    @(posedge core_clk) disable iff (!blkRstN)
    (!fetchSlot && !dataCyc_q) |=> (p0Out == '0) && (p0Oe == ~$past(p0Lat_q));
  endproperty
  a_p0_open: assert property (p_p0_open) else $error("port 0 not open drain");

  property p_latch_kept;
    @(posedge core_clk) disable iff (!blkRstN)
    (dataCyc_q && !sfrReq.wrEn) |=> $stable(p0Lat_q) && $stable(p2Lat_q);
  endproperty
  a_latch_kept: assert property (p_latch_kept) else $error("bus cycle changed a latch");
endmodule
`default_nettype wire

// file: sim/ext_mem.sv
`timescale 1ns/10ps
`default_nettype none
module ext_mem (
  input  wire logic       core_clk,
  input  wire logic       ale,
  input  wire logic       fetchN,
  input  wire logic       rdN,
  input  wire logic       wrN,
  input  wire logic [7:0] p0,
  input  wire logic [7:0] p2,
  output logic      [7:0] busOut,
  output logic            busOe,
  output logic      [7:0] lastWr
);
  logic [7:0] addrLo;
  // register loaded on every clock edge while the pulse is high, holds once it falls
  always_ff @(posedge core_clk) begin
    if (ale) addrLo <= p0;
    if (!wrN) lastWr <= p0;
  end
  assign busOe  = !fetchN || !rdN;
  assign busOut = !fetchN ? addrLo ^ p2 : ~addrLo;
endmodule
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  port_bus_pkg::sfr_req_t sfrReq = '0;
  port_bus_pkg::xdata_req_t xReqData = '0;
  logic [15:0] fetchAddr = 16'h1234;
  logic xReq = 1'b0, codeConst = 1'b0, extSelN = 1'b1, lock1 = 1'b0, rstPin = 1'b0, fetchOn = 1'b0;
  logic [7:0] p0In, p0Out, p0Oe, p1Out, p1Oe, p2Out, p2Oe, p3Out, p3Oe, sfrRd, xRd, fetchData, busOut, lastWr;
  logic [7:0] p1Pin, p2Pin, p3Pin, p1Ext = 8'hFF, p3Ext = 8'hFF, flt = 8'h00, p2Seen, rv, wv, v2;
  logic [7:0] ptrLo, ptrHi, ind, wd;
  logic fetchValid, xDone, ale, psN, extExec, devRst, busOe, aleP, psP;
  logic [6:0] altIn;
  int miscompares = 0, numChecks = 0, aleCnt, psCnt, cyc;
  logic [7:0] rstA [7] = '{8'h90, 8'hA0, 8'hB0, 8'h82, 8'h83, 8'h8E, 8'h81};
  logic [7:0] rstE [7] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
  always #5 core_clk = ~core_clk;
  assign p1Pin = (p1Oe & p1Out) | (~p1Oe & p1Ext);
  assign p2Pin = (p2Oe & p2Out) | ~p2Oe;
  assign p3Pin = (p3Oe & p3Out) | (~p3Oe & p3Ext);
  // released bus shows a moving pattern, never a stale value
  assign p0In = busOe ? busOut : (p0Oe & p0Out) | (~p0Oe & flt);
  port_bus_ctrl dut (
    .core_clk(core_clk), .rstn(rstn), .sfrReq(sfrReq), .sfrRdData_q(sfrRd), .fetchAddr(fetchAddr),
    .fetchData_q(fetchData), .fetchValid_q(fetchValid), .codeConstActive(codeConst), .xReq(xReq),
    .xReqData(xReqData), .xRdData_q(xRd), .xDone_q(xDone), .aleOut_q(ale), .programFetchStrobeN_q(psN),
    .extFetchSelectN(extSelN), .lockBit1(lock1), .rstPin(rstPin), .extExec(extExec), .deviceReset(devRst),
    .p0In(p0In), .p0Out(p0Out), .p0Oe(p0Oe), .p1In(p1Pin), .p1Out(p1Out), .p1Oe(p1Oe), .p2In(p2Pin),
    .p2Out(p2Out), .p2Oe(p2Oe), .p3In(p3Pin), .p3Out(p3Out), .p3Oe(p3Oe), .txdOut(1'b1),
    .timer2ClkOut(1'b0), .timer2ClkOutEn(1'b0), .serialRxd_q(altIn[0]), .extIrq0Pin_q(altIn[1]),
    .extIrq1Pin_q(altIn[2]), .timer0CountPin_q(altIn[3]), .timer1CountPin_q(altIn[4]),
    .timer2CountInput_q(altIn[5]), .timer2TriggerInput_q(altIn[6])
  );
  ext_mem mem (
    .core_clk(core_clk), .ale(ale), .fetchN(psN), .rdN(p3Pin[7]), .wrN(p3Pin[6]), .p0(p0In), .p2(p2Pin),
    .busOut(busOut), .busOe(busOe), .lastWr(lastWr)
  );
  function automatic logic [7:0] fx(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    numChecks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic completeRun();
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic sfrWr(input logic [7:0] a, input logic [7:0] d);
    sfrReq = '{a, 1'b1, 1'b0, d};
    tick(1);
    sfrReq = '0;
    tick(1);
  endtask
  task automatic sfrGet(input logic [7:0] a);
    sfrReq = '{a, 1'b0, 1'b1, 8'h00};
    tick(1);
    sfrReq = '0;
    rv = sfrRd;
    tick(1);
  endtask
  task automatic span(input logic doX, input logic w, input logic dp);
    aleCnt = 0;
    psCnt = 0;
    cyc = 0;
    if (doX) begin
      xReqData = '{w, dp, ind, wd};
      xReq = 1'b1;
      for (int i = 0; i < 40 && xDone !== 1'b1; i++) tick(1);
      if (xDone !== 1'b1) begin
        miscompares++;
        completeRun();
      end
      xReq = 1'b0;
    end
    while (cyc < 120) tick(1);
  endtask
  // strap changes in the last clock of a data access, one clock before the machine cycle boundary
  task automatic syncMcyc();
    xReq = 1'b1;
    for (int i = 0; i < 40 && xDone !== 1'b1; i++) tick(1);
    if (xDone !== 1'b1) miscompares++;
    xReq = 1'b0;
  endtask
  // fetch results read once settled, never in the edge's own time step
  always @(posedge core_clk) begin
    #1;
    if (fetchOn && fetchValid) begin
      chk(fetchData, fx(fetchAddr));
      fetchAddr = 16'($urandom);
    end
  end
  always @(posedge core_clk) begin
    aleP <= ale;
    psP <= psN;
    flt <= flt + 8'h5B;
    cyc <= cyc + 1;
    if (ale && !aleP) aleCnt <= aleCnt + 1;
    if (!psN && psP) psCnt <= psCnt + 1;
    if (!p3Pin[7]) p2Seen <= p2Pin;
  end
  initial begin
    void'($urandom(32'h1E7E));
    tick(2);
    rstn = 1'b1;
    tick(1);
    foreach (rstA[i]) begin
      sfrGet(rstA[i]);
      chk(rv, rstE[i]);
    end
    chk(p0Oe, 8'h00);
    chk({7'h00, extExec}, 8'h00);
    sfrWr(8'h80, 8'h5A);
    tick(2);
    chk(p0Oe, 8'hA5);
    chk(p0Out & p0Oe, 8'h00);
    sfrWr(8'h80, 8'hFF);
    for (int i = 0; i < 3; i++) begin
      wv = $urandom;
      v2 = (i == 1) ? wv : v2;
      sfrWr(rstA[i], wv);
      tick(2);
      sfrGet(rstA[i]);
      chk(rv, wv);
      if (i != 1) sfrWr(rstA[i], 8'hFF);
    end
    p1Ext = $urandom;
    p3Ext = {2'b11, 6'($urandom)};
    tick(3);
    chk({1'b0, altIn}, {1'b0, p1Ext[1:0], p3Ext[5:2], p3Ext[0]});
    p1Ext = 8'hFF;
    p3Ext = 8'hFF;
    ptrLo = $urandom;
    ptrHi = $urandom;
    ind = $urandom;
    wd = $urandom;
    sfrWr(8'h82, ptrLo);
    sfrWr(8'h83, ptrHi);
    span(1'b0, 1'b0, 1'b0);
    chk(8'(aleCnt), 8'h14);
    span(1'b1, 1'b0, 1'b1);
    chk(8'(aleCnt), 8'h13);
    chk(xRd, ~ptrLo);
    chk(p2Seen, ptrHi);
    span(1'b1, 1'b0, 1'b0);
    chk(xRd, ~ind);
    chk(p2Seen, v2);
    span(1'b1, 1'b1, 1'b0);
    chk(lastWr, wd);
    sfrGet(8'hA0);
    chk(rv, v2);
    sfrWr(8'h8E, 8'h01);
    sfrGet(8'h8E);
    chk(rv, 8'h01);
    tick(12);
    span(1'b0, 1'b0, 1'b0);
    chk(8'(aleCnt), 8'h00);
    codeConst = 1'b1;
    tick(12);
    span(1'b0, 1'b0, 1'b0);
    chk(8'(aleCnt), 8'h14);
    codeConst = 1'b0;
    syncMcyc();
    extSelN = 1'b0;
    tick(2);
    chk({7'h00, extExec}, 8'h01);
    fetchOn = 1'b1;
    tick(12);
    span(1'b0, 1'b0, 1'b0);
    chk(8'(aleCnt), 8'h14);
    chk(8'(psCnt), 8'h14);
    span(1'b1, 1'b0, 1'b1);
    chk(8'(aleCnt), 8'h13);
    chk(8'(psCnt), 8'h12);
    fetchOn = 1'b0;
    syncMcyc();
    lock1 = 1'b1;
    tick(2);
    chk({7'h00, extExec}, 8'h00);
    sfrWr(8'h90, 8'h00);
    rstPin = 1'b1;
    tick(20);
    chk({7'h00, devRst}, 8'h00);
    tick(8);
    chk({7'h00, devRst}, 8'h01);
    rstPin = 1'b0;
    tick(3);
    sfrGet(8'h90);
    chk(rv, 8'hFF);
    completeRun();
  end
endmodule
`default_nettype wire
